// File: dals_chk.sv
// Purpose: Port assertions for the drive alarm latch and status block.
// Assumes: Watched inputs stay steady while clk_en is low.
// Notes: Bound to dals_top from the bench top file.
`timescale 1ns/1ns
module dals_chk (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus side, to spot a software restart.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  // Alarm side.
  input wire logic [15:0] alarm_in,
  input wire logic drive_restart,
  input wire logic [15:0] active_alarm_mask,
  input wire logic [15:0] first_alarm_code_out,
  input wire logic [4:0] first_alarm_ordinal,
  input wire logic [4:0] last_alarm_ordinal,
  input wire logic trip_out,
  // Status side.
  input wire logic stall_flag,
  input wire logic zero_speed_flag,
  input wire logic zero_setpoint_flag,
  input wire logic standstill_flag,
  input wire logic prog_stop_term,
  input wire logic net_prog_stop,
  input wire logic net_start,
  input wire logic program_stop_out,
  input wire logic drive_start_out,
  input wire logic signed [15:0] setpoint_in0,
  input wire logic signed [15:0] setpoint_in1,
  input wire logic signed [16:0] setpoint_sum_out
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // No live alarm and no stall, so a restart cannot recapture.
  wire logic quiet = (alarm_in == 16'h0000) && !stall_flag;
  // The stall bit is left out because it comes from derived quantities.
  AST_MASK: assert property ($past(presetn) |->
    (active_alarm_mask & 16'hefff) == ($past(alarm_in) & 16'hefff))
    else $error("active mask does not follow alarms");
  AST_ONEHOT: assert property ($onehot0(first_alarm_code_out))
    else $error("capture is not one-hot");
  AST_ORD: assert property (first_alarm_code_out ==
    (first_alarm_ordinal == 5'h00 ? 16'h0000 :
    16'h0001 << (first_alarm_ordinal - 5'h01)))
    else $error("ordinal does not match capture");
  AST_TRIP: assert property (trip_out == (first_alarm_code_out != 0))
    else $error("trip output disagrees with capture");
  // A write to the control word may restart the drive, like the pin.
  AST_HOLD: assert property (trip_out && !drive_restart &&
    !(psel && penable && pwrite && paddr == 8'h00) |=>
    $stable(first_alarm_code_out) && $stable(last_alarm_ordinal))
    else $error("capture changed while tripped");
  AST_CLEAR: assert property (drive_restart && quiet |=>
    first_alarm_code_out == 16'h0000 && $stable(last_alarm_ordinal))
    else $error("restart clear wrong");
  AST_MAIN: assert property (!trip_out && alarm_in == 16'h0200 |=>
    first_alarm_ordinal == 5'h0a && last_alarm_ordinal == 5'h0a)
    else $error("supply alarm not latched");
  AST_SUM: assert property ($past(presetn) |-> setpoint_sum_out ==
    $past(setpoint_in0) + $past(setpoint_in1))
    else $error("setpoint sum wrong");
  AST_PSTOP: assert property ($past(presetn) |->
    program_stop_out == ($past(prog_stop_term) & $past(net_prog_stop)))
    else $error("program stop wrong");
  AST_START: assert property ($past(presetn) |->
    drive_start_out == $past(net_start))
    else $error("drive start wrong");
  AST_STAND: assert property (standstill_flag ==
    (zero_speed_flag && zero_setpoint_flag))
    else $error("standstill wrong");
  AST_STALL: assert property (stall_flag |->
    zero_speed_flag && !zero_setpoint_flag)
    else $error("stall without its conditions");
endmodule

// File: dals_pkg.sv
// Purpose: Shared constants for the drive alarm latch and status block.
// Assumes: 20 MHz pclk, APB register access, 16 alarm sources.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package dals_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned ALARM_N = 16;
  localparam int unsigned ORD_W = 5;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned OVERSPEED_DLY_MS = 750;
  localparam int unsigned MISS_PULSE_DLY_MS = 60000;
  localparam int unsigned MOTOR_TEMP_DLY_MS = 15000;
  localparam int unsigned SPD_FBK_DLY_MS = 100;
  localparam int unsigned PHASE_LOCK_DLY_MS = 500;
  localparam int unsigned OVERSPEED_DLY_CYC = OVERSPEED_DLY_MS * CYC_PER_MS;
  localparam int unsigned MISS_PULSE_DLY_CYC = MISS_PULSE_DLY_MS * CYC_PER_MS;
  localparam int unsigned MOTOR_TEMP_DLY_CYC = MOTOR_TEMP_DLY_MS * CYC_PER_MS;
  localparam int unsigned SPD_FBK_DLY_CYC = SPD_FBK_DLY_MS * CYC_PER_MS;
  localparam int unsigned PHASE_LOCK_DLY_CYC = PHASE_LOCK_DLY_MS * CYC_PER_MS;

  // ****************************************
  // Alarm bit positions and masks
  // ****************************************
  localparam int unsigned OVERSPEED_BIT = 0;
  localparam int unsigned MISS_PULSE_BIT = 1;
  localparam int unsigned MOTOR_TEMP_BIT = 4;
  localparam int unsigned SPD_FBK_BIT = 6;
  localparam int unsigned PHASE_LOCK_BIT = 10;
  localparam logic [15:0] STALL_MASK = 16'h1000;
  localparam logic [15:0] INHIBITABLE_MASK = 16'h10c0;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] INHIBIT_OFS = 8'h04;
  localparam logic [7:0] RAMP_THR_OFS = 8'h08;
  localparam logic [7:0] ZSPD_THR_OFS = 8'h0c;
  localparam logic [7:0] STALL_THR_OFS = 8'h10;
  localparam logic [7:0] ACTIVE_OFS = 8'h14;
  localparam logic [7:0] CAPTURE_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1c;
  localparam logic [7:0] SUM_OFS = 8'h20;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned CTRL_RESTART_POS = 0;
  localparam int unsigned ST_FIRST_POS = 0;
  localparam int unsigned ST_LAST_POS = 8;
  localparam int unsigned ST_FLAG_POS = 16;
  localparam logic [15:0] INHIBIT_RST = 16'h0000;
  localparam logic [15:0] RAMP_THR_RST = 16'h0100;
  localparam logic [15:0] ZSPD_THR_RST = 16'h0040;
  localparam logic [15:0] STALL_THR_RST = 16'h4000;
endpackage

// File: dals_top.sv
// Purpose: Alarm capture and diagnostic status flags of a motor drive.
// Assumes: Inputs synchronous to pclk; presetn is control power loss.
// Notes: Registers reached over APB, zero wait states while clk_en is high.
//
// Operation
// - Trip on first detected alarm, latch it.
// - Last alarm holds until later trip or power loss.
// - Capture register stores one-hot tripping alarm code.
// - Restart clears the capture register to zero, unless an alarm trips in that cycle.
// - Further alarms ignored until next restart.
// - Active mask follows present alarms every enabled cycle.
// - Power loss zeroes mask, capture, last alarm.
// - Ordinal output of capture, zero when empty.
// - Ordinals 1 to 16 map to one-hot bits.
// - Per-alarm delay; only inhibitable alarms suppressible.
// - Ramping when ramp difference exceeds threshold.
// - Stall on high current, zero speed, nonzero setpoint.
// - Standstill is zero speed with zero demand.
// - Current flag while demand clamped by limit.
// - Program stop is terminal AND network input.
// - Setpoint sum is input 0 plus input 1.
// - Drive start follows network start command.
// - Diagnostic points are read-only to software.
`timescale 1ns/1ns
module dals_top
  import dals_pkg::*;
#(
  parameter logic [31:0] OVERSPEED_CYC = OVERSPEED_DLY_CYC,
  parameter logic [31:0] MISS_PULSE_CYC = MISS_PULSE_DLY_CYC,
  parameter logic [31:0] MOTOR_TEMP_CYC = MOTOR_TEMP_DLY_CYC,
  parameter logic [31:0] SPD_FBK_CYC = SPD_FBK_DLY_CYC,
  parameter logic [31:0] PHASE_LOCK_CYC = PHASE_LOCK_DLY_CYC
) (
  // Clock, reset and clock enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Alarm sources and drive restart pulse.
  input wire logic [15:0] alarm_in,
  input wire logic drive_restart,
  // Drive quantities, signed two's complement except arm_current and current_limit.
  input wire logic signed [15:0] ramp_in,
  input wire logic signed [15:0] ramp_out,
  input wire logic signed [15:0] speed_fbk,
  input wire logic signed [15:0] speed_demand,
  input wire logic [15:0] arm_current,
  input wire logic signed [15:0] current_demand,
  input wire logic [15:0] current_limit,
  input wire logic signed [15:0] setpoint_in0,
  input wire logic signed [15:0] setpoint_in1,
  // Start and program stop inputs.
  input wire logic prog_stop_term,
  input wire logic net_prog_stop,
  input wire logic net_start,
  // Alarm outputs.
  output logic [15:0] active_alarm_mask,
  output logic [15:0] first_alarm_code_out,
  output logic [4:0] first_alarm_ordinal,
  output logic [4:0] last_alarm_ordinal,
  output logic trip_out,
  // Diagnostic outputs.
  output logic ramping_flag,
  output logic zero_speed_flag,
  output logic zero_setpoint_flag,
  output logic standstill_flag,
  output logic current_clamped_flag,
  output logic stall_flag,
  output logic program_stop_out,
  output logic drive_start_out,
  output logic signed [16:0] setpoint_sum_out
);

  // ****************************************
  // Helpers
  // ****************************************

  // Magnitude of a 17-bit signed value; fits 17 bits unsigned.
  function automatic logic [16:0] mag17(input logic signed [16:0] v);
    mag17 = v[16] ? 17'(-v) : v;
  endfunction

  // Ordinal of a one-hot code, zero for an empty code.
  function automatic logic [4:0] ord_of(input logic [15:0] code);
    ord_of = 5'h00;
    for (int k = 0; k < 16; k++) begin
      if (code[k]) begin
        ord_of = 5'(k + 1);
      end
    end
  endfunction

  // ****************************************
  // Register bus
  // ****************************************

  logic [15:0] inhibit_r; // Alarm inhibit settings.
  logic [15:0] ramp_thr_r; // Ramping threshold.
  logic [15:0] zspd_thr_r; // Zero speed threshold.
  logic [15:0] stall_thr_r; // Stall current threshold.
  logic [31:0] prdata_r; // Read data staged in setup.
  logic pslverr_r; // Error staged in setup.
  logic setup_c; // Setup phase of a transfer.
  logic wr_c; // Write takes effect this edge.
  logic hit_c; // Address is mapped.
  logic [15:0] wmask_c; // Byte lanes of the low half.
  logic sw_restart_c; // Restart written by software.
  logic [31:0] rd_c; // Read mux.
  logic [31:0] status_c; // Packed status word.

  // No wait states; a low clock enable stretches the access.
  assign pready = clk_en;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign setup_c = psel & ~penable;
  assign wr_c = psel & penable & pwrite & clk_en & ~pslverr_r;
  assign wmask_c = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign sw_restart_c = wr_c & (paddr == CTRL_OFS) & pstrb[0] &
                        pwdata[CTRL_RESTART_POS];

  // Decode and read mux; read-only points simply take no write.
  always_comb begin
    hit_c = 1'b1;
    rd_c = 32'h0000_0000;
    case (paddr)
      CTRL_OFS: rd_c = 32'h0000_0000;
      INHIBIT_OFS: rd_c = {16'h0000, inhibit_r};
      RAMP_THR_OFS: rd_c = {16'h0000, ramp_thr_r};
      ZSPD_THR_OFS: rd_c = {16'h0000, zspd_thr_r};
      STALL_THR_OFS: rd_c = {16'h0000, stall_thr_r};
      ACTIVE_OFS: rd_c = {16'h0000, active_alarm_mask};
      CAPTURE_OFS: rd_c = {16'h0000, first_alarm_code_out};
      STATUS_OFS: rd_c = status_c;
      SUM_OFS: rd_c = 32'(setpoint_sum_out);
      default: hit_c = 1'b0;
    endcase
  end

  // Status word packs ordinals, trip and every flag.
  assign status_c = (32'(first_alarm_ordinal) << ST_FIRST_POS) |
                    (32'(last_alarm_ordinal) << ST_LAST_POS) |
                    (32'({drive_start_out, program_stop_out, stall_flag,
                          current_clamped_flag, standstill_flag,
                          zero_setpoint_flag, zero_speed_flag,
                          ramping_flag, trip_out}) << ST_FLAG_POS);

  // Read data and error are staged in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (clk_en && setup_c) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_c;
      pslverr_r <= ~hit_c;
    end
  end

  // Configuration registers; only inhibitable bits of the inhibit register can be set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_r <= INHIBIT_RST;
      ramp_thr_r <= RAMP_THR_RST;
      zspd_thr_r <= ZSPD_THR_RST;
      stall_thr_r <= STALL_THR_RST;
    end else if (wr_c) begin
      case (paddr)
        INHIBIT_OFS: begin
          inhibit_r <= ((inhibit_r & ~wmask_c) | (pwdata[15:0] & wmask_c)) &
                       INHIBITABLE_MASK;
        end
        RAMP_THR_OFS: begin
          ramp_thr_r <= (ramp_thr_r & ~wmask_c) | (pwdata[15:0] & wmask_c);
        end
        ZSPD_THR_OFS: begin
          zspd_thr_r <= (zspd_thr_r & ~wmask_c) | (pwdata[15:0] & wmask_c);
        end
        STALL_THR_OFS: begin
          stall_thr_r <= (stall_thr_r & ~wmask_c) | (pwdata[15:0] & wmask_c);
        end
        // Diagnostic offsets ignore writes.
        default: begin
          inhibit_r <= inhibit_r;
        end
      endcase
    end
  end

  // ****************************************
  // Diagnostic flags
  // ****************************************

  logic zspd_c; // Speed feedback near zero.
  logic zsp_c; // Speed demand near zero.

  assign zspd_c = mag17(17'(speed_fbk)) < {1'b0, zspd_thr_r};
  assign zsp_c = mag17(17'(speed_demand)) < {1'b0, zspd_thr_r};

  // All flags are registered every enabled cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramping_flag <= 1'b0;
      zero_speed_flag <= 1'b0;
      zero_setpoint_flag <= 1'b0;
      standstill_flag <= 1'b0;
      current_clamped_flag <= 1'b0;
      stall_flag <= 1'b0;
      program_stop_out <= 1'b0;
      drive_start_out <= 1'b0;
      setpoint_sum_out <= 17'h00000;
    end else if (clk_en) begin
      ramping_flag <= mag17(17'(ramp_in) - 17'(ramp_out)) >
                      {1'b0, ramp_thr_r};
      zero_speed_flag <= zspd_c;
      zero_setpoint_flag <= zsp_c;
      standstill_flag <= zspd_c & zsp_c;
      current_clamped_flag <= mag17(17'(current_demand)) >
                              {1'b0, current_limit};
      stall_flag <= (arm_current > stall_thr_r) & zspd_c & ~zsp_c;
      program_stop_out <= prog_stop_term & net_prog_stop;
      drive_start_out <= net_start;
      setpoint_sum_out <= 17'(setpoint_in0) + 17'(setpoint_in1);
    end
  end

  // ****************************************
  // Alarm qualification
  // ****************************************

  logic [15:0] present_c; // Alarms present now.
  logic [15:0] matured_c; // Alarms past their delay.
  logic [15:0] trip_c; // Alarms that may trip.
  logic [15:0] lowest_c; // Lowest trip candidate.
  logic restart_c; // Pin or software restart.

  // The stall condition feeds its own alarm bit.
  assign present_c = alarm_in | (stall_flag ? STALL_MASK : 16'h0000);

  // One saturating delay counter per alarm; a dropout restarts it.
  for (genvar i = 0; i < ALARM_N; i++) begin : g_dly
    localparam logic [31:0] DLY =
      (i == OVERSPEED_BIT) ? OVERSPEED_CYC :
      (i == MISS_PULSE_BIT) ? MISS_PULSE_CYC :
      (i == MOTOR_TEMP_BIT) ? MOTOR_TEMP_CYC :
      (i == SPD_FBK_BIT) ? SPD_FBK_CYC :
      (i == PHASE_LOCK_BIT) ? PHASE_LOCK_CYC : 32'h0000_0000;
    logic [31:0] cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_r <= 32'h0000_0000;
      end else if (clk_en) begin
        if (!present_c[i]) begin
          cnt_r <= 32'h0000_0000;
        end else if (cnt_r < DLY) begin
          cnt_r <= cnt_r + 32'h0000_0001;
        end
      end
    end
    assign matured_c[i] = present_c[i] && (cnt_r >= DLY);
  end

  // Inhibit acts only on inhibitable alarms.
  assign trip_c = matured_c & ~(inhibit_r & INHIBITABLE_MASK);
  // Two's complement trick isolates the lowest set bit.
  assign lowest_c = trip_c & (~trip_c + 16'h0001);
  assign restart_c = drive_restart | sw_restart_c;

  // ****************************************
  // Alarm capture
  // ****************************************

  // Live mask of present alarms, no latching.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_alarm_mask <= 16'h0000;
    end else if (clk_en) begin
      active_alarm_mask <= present_c;
    end
  end

  // First trip capture. A trip in the restart cycle wins over the
  // clear, so an alarm still present re-trips at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_alarm_code_out <= 16'h0000;
      first_alarm_ordinal <= 5'h00;
      last_alarm_ordinal <= 5'h00;
      trip_out <= 1'b0;
    end else if (clk_en) begin
      if ((|trip_c) && (!trip_out || restart_c)) begin
        first_alarm_code_out <= lowest_c;
        first_alarm_ordinal <= ord_of(lowest_c);
        last_alarm_ordinal <= ord_of(lowest_c);
        trip_out <= 1'b1;
      end else if (restart_c) begin
        // Last alarm stays; only the capture clears.
        first_alarm_code_out <= 16'h0000;
        first_alarm_ordinal <= 5'h00;
        trip_out <= 1'b0;
      end
      // While tripped, later alarms change nothing.
    end
  end

endmodule

// File: test_drive_alarm_latch_and_status.sv
// Purpose: Self-checking bench for the drive alarm latch and status block.
// Assumes: Short alarm delays set by parameter.
// Notes: Random drive quantities come from a fixed-seed shift register.
`timescale 1ns/1ns
module test_drive_alarm_latch_and_status;
  import dals_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] pstrb = 4'hf;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, drive_restart = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'he912;
  logic pready, pslverr, err;
  logic [15:0] alarm_in = '0, arm_current = '0, current_limit = '0;
  logic signed [15:0] ramp_in = '0, ramp_out = '0, speed_fbk = '0;
  logic signed [15:0] speed_demand = '0, current_demand = '0;
  logic signed [15:0] setpoint_in0 = '0, setpoint_in1 = '0;
  logic prog_stop_term = 1'b0, net_prog_stop = 1'b0, net_start = 1'b0;
  logic [15:0] active_alarm_mask, first_alarm_code_out;
  logic [4:0] first_alarm_ordinal, last_alarm_ordinal;
  logic trip_out, ramping_flag, zero_speed_flag, zero_setpoint_flag;
  logic standstill_flag, current_clamped_flag, stall_flag;
  logic program_stop_out, drive_start_out;
  logic signed [16:0] setpoint_sum_out;
  int bad_count = 0, checked = 0, n;
  // Delay per alarm bit, matching the parameters handed to the design.
  int dl [16] = '{4, 5, 0, 0, 6, 0, 7, 0, 0, 0, 8, 0, 0, 0, 0, 0};
  logic [7:0] ofs [8] = '{INHIBIT_OFS, RAMP_THR_OFS, ZSPD_THR_OFS,
    STALL_THR_OFS, ACTIVE_OFS, CAPTURE_OFS, STATUS_OFS, SUM_OFS};
  // Quiet inputs give zero speed, zero setpoint and standstill.
  logic [31:0] rv [8] = '{32'h0, 32'h100, 32'h40, 32'h4000, 32'h0, 32'h0,
    32'h001c0000, 32'h0};
  dals_top #(.OVERSPEED_CYC(32'd4), .MISS_PULSE_CYC(32'd5),
    .MOTOR_TEMP_CYC(32'd6), .SPD_FBK_CYC(32'd7), .PHASE_LOCK_CYC(32'd8))
    dals_top_inst (.pclk, .presetn, .clk_en, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .alarm_in,
    .drive_restart, .ramp_in, .ramp_out, .speed_fbk, .speed_demand,
    .arm_current, .current_demand, .current_limit, .setpoint_in0,
    .setpoint_in1, .prog_stop_term, .net_prog_stop, .net_start,
    .active_alarm_mask, .first_alarm_code_out, .first_alarm_ordinal,
    .last_alarm_ordinal, .trip_out, .ramping_flag, .zero_speed_flag,
    .zero_setpoint_flag, .standstill_flag, .current_clamped_flag,
    .stall_flag, .program_stop_out, .drive_start_out, .setpoint_sum_out);
  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    forever #25 pclk = ~pclk;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function logic [31:0] nx(input logic [31:0] x);
    for (int i = 0; i < 8; i++) begin
      x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    end
    return x;
  endfunction
  function int ab(input int v);
    return v < 0 ? -v : v;
  endfunction
  // Flags expected from the present inputs and the reset thresholds.
  function logic [7:0] fx();
    logic zs, zp;
    zs = ab(int'(speed_fbk)) < 'h40;
    zp = ab(int'(speed_demand)) < 'h40;
    return {ab(int'(ramp_in) - int'(ramp_out)) > 'h100, zs, zp, zs && zp,
      ab(int'(current_demand)) > int'(current_limit),
      arm_current > 16'h4000 && zs && !zp,
      prog_stop_term & net_prog_stop, net_start};
  endfunction
  // One APB transfer; the request holds until pready is seen high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task restart;
    @(posedge pclk);
    drive_restart <= 1'b1;
    @(posedge pclk);
    drive_restart <= 1'b0;
  endtask
  // Apply alarms and wait a bounded time for the trip.
  task raise(input logic [15:0] a, input int lim);
    @(posedge pclk);
    alarm_in <= a;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (trip_out !== 1'b1 && n < lim);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk("reset value", rd, rv[i]);
      if (i > 3) begin
        apb(1'b1, ofs[i], 32'hffffffff);
        apb(1'b0, ofs[i], 32'h0);
        chk("read only", rd, rv[i]);
      end
    end
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    // Only the low byte lane is written; the high byte keeps 0x01.
    @(posedge pclk);
    pstrb <= 4'h1;
    apb(1'b1, RAMP_THR_OFS, 32'hffff);
    pstrb <= 4'hf;
    apb(1'b0, RAMP_THR_OFS, 32'h0);
    chk("byte lane", rd, 32'h1ff);
    apb(1'b1, RAMP_THR_OFS, 32'h100);
    // A low clock enable must freeze the flags and hold pready low.
    @(posedge pclk);
    clk_en <= 1'b0;
    current_demand <= 16'sh7fff;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("frozen", {pready, current_clamped_flag}, 2'b00);
    @(posedge pclk);
    clk_en <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chk("thawed", {pready, current_clamped_flag}, 2'b11);
    repeat (40) begin
      @(posedge pclk);
      seed = nx(seed);
      ramp_in <= {{6{seed[9]}}, seed[9:0]};
      ramp_out <= {{6{seed[19]}}, seed[19:10]};
      speed_fbk <= {{8{seed[27]}}, seed[27:20]};
      {prog_stop_term, net_prog_stop, net_start} <= seed[30:28];
      arm_current <= {seed[31], seed[14:0]};
      seed = nx(seed);
      speed_demand <= {{8{seed[7]}}, seed[7:0]};
      current_demand <= {{4{seed[19]}}, seed[19:8]};
      current_limit <= {4'h0, seed[31:20]};
      setpoint_in0 <= seed[15:0];
      setpoint_in1 <= seed[31:16];
      @(posedge pclk);
      @(negedge pclk);
      chk("flags", {ramping_flag, zero_speed_flag, zero_setpoint_flag,
        standstill_flag, current_clamped_flag, stall_flag, program_stop_out,
        drive_start_out}, fx());
      chk("sum", setpoint_sum_out, setpoint_in0 + setpoint_in1);
    end
    @(posedge pclk);
    speed_demand <= '0;
    for (int k = 0; k < 16; k++) begin
      restart;
      raise(16'h0001 << k, 20);
      chk("delay", n, dl[k] + 2);
      chk("code", first_alarm_code_out, 16'h0001 << k);
      chk("ordinal", {first_alarm_ordinal, last_alarm_ordinal},
        {5'(k + 1), 5'(k + 1)});
      chk("mask", active_alarm_mask, 16'h0001 << k);
      @(posedge pclk);
      alarm_in <= '0;
    end
    restart;
    raise(16'h0600, 20);
    @(posedge pclk);
    alarm_in <= 16'h0003;
    repeat (8) @(negedge pclk);
    chk("held code", first_alarm_code_out, 16'h0200);
    chk("mask", active_alarm_mask, 16'h0003);
    @(posedge pclk);
    alarm_in <= '0;
    restart;
    @(negedge pclk);
    chk("cleared", {trip_out, first_alarm_code_out}, 17'h0);
    chk("last kept", last_alarm_ordinal, 5'h0a);
    raise(16'h2008, 10);
    chk("lowest wins", first_alarm_code_out, 16'h0008);
    @(posedge pclk);
    alarm_in <= '0;
    apb(1'b1, CTRL_OFS, 32'h1);
    apb(1'b1, INHIBIT_OFS, 32'hffff);
    apb(1'b0, INHIBIT_OFS, 32'h0);
    chk("inhibit", rd, 32'h10c0);
    chk("reg restart", first_alarm_code_out, 16'h0);
    raise(16'h0080, 10);
    chk("inhibited", trip_out, 1'b0);
    raise(16'h0280, 10);
    chk("not inhibitable", first_alarm_code_out, 16'h0200);
    @(posedge pclk);
    alarm_in <= '0;
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("power loss", {active_alarm_mask, first_alarm_code_out},
      32'h0);
    chk("power loss last", last_alarm_ordinal, 5'h0);
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    print_verdict;
  end
endmodule
bind dals_top dals_chk chk_inst (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .alarm_in, .drive_restart,
  .active_alarm_mask, .first_alarm_code_out, .first_alarm_ordinal,
  .last_alarm_ordinal, .trip_out, .stall_flag, .zero_speed_flag,
  .zero_setpoint_flag, .standstill_flag, .prog_stop_term, .net_prog_stop,
  .net_start, .program_stop_out, .drive_start_out, .setpoint_in0,
  .setpoint_in1, .setpoint_sum_out);
